//--- dtc_ctrl.sv
// Die temperature sequencer, gain correction, sample period and pulse outputs.
// Assumes a converter and metering datapath on clk_i, and a host reaching
// the registers through a plain strobe port.
`timescale 1ns/1ps

// How it works
// [R1] Conversions start only from a host write of a command bit.
// [R2] Single command: one normal-bias conversion, store raw, self-clear the bit.
// [R3] Double command: normal-bias conversion then reversed-bias conversion.
// [R4] Double result is averaged, stored, then both command bits clear.
// [R5] Raw temperature holds the unscaled converter sample.
// [R6] The host scales the raw temperature to a unit.
// [R7] Completion sets the temperature-ready flag in the first flag register.
// [R8] Ready flag and its enable together raise the interrupt request.
// [R9] Host reads the result, then clears the ready flag.
// [R10] Host reloads coefficients after every reset; they reset to zero.
// [R11] Full-scale RMS input reads as two to the thirtieth.
// [R12] Full-scale power gives two to the eighteenth over line-rate times period.
// [R13] Pulse config codes pick one phase's apparent energy per pulse output.
// [R14] Pulse 1 drives the active pin with threshold 1; pulse 2 the second.
// [R15] One pulse per threshold amount of accumulated energy, at most one per sample tick; none with a zero threshold.
// [R16] Thresholds are 32-bit registers.
// [R17] Sample period is (rate setting + 1) times eight clocks; default 199.
// [R18] Gain coefficients are host-writable and reset to zero.
// [R19] Raw results are scaled by one plus coefficient over 65536.
// [R20] Commands written during a conversion are ignored.
module dtc_ctrl
  import dtc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [`DTC_ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  output logic conv_start_o,
  output logic bias_rev_o,
  input wire logic conv_done_i,
  input wire logic [15:0] conv_data_i,
  input wire logic [31:0] irms_raw_i,
  input wire logic [31:0] vrms_raw_i,
  input wire logic [31:0] energy_raw_i,
  output logic [31:0] irms_corr_o,
  output logic [31:0] vrms_corr_o,
  output logic [31:0] energy_corr_o,
  input wire logic [31:0] va_energy_a_i,
  input wire logic [31:0] va_energy_b_i,
  input wire logic [31:0] va_energy_c_i,
  output logic sample_tick_o,
  output logic active_pulse_pin_o,
  output logic second_pulse_pin_o
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [1:0] heat_conv_cmd_bits_q, heat_conv_cmd_bits_d;
  logic irq_en_q, irq_en_d;
  logic heat_ready_flag_q, heat_ready_flag_d;
  logic [15:0] raw_temp_q, raw_temp_d;
  logic [15:0] first_res_q, first_res_d;
  dtc_coef_t gain_q [3];
  dtc_coef_t gain_d [3];
  logic [15:0] pulse_source_config_q, pulse_source_config_d;
  logic [31:0] thr_q [2];
  logic [31:0] thr_d [2];
  logic [15:0] sample_rate_setting_q, sample_rate_setting_d;
  logic [31:0] rdata_q, rdata_d;
  dtc_state_t state_q, state_d;
  logic start_q, start_d;
  logic bias_q, bias_d;
  logic busy;
  logic [16:0] temp_sum;

  assign busy = (state_q != DTC_IDLE);
  assign temp_sum = {1'b0, first_res_q} + {1'b0, conv_data_i};

  // ----------------------------------------
  // Host register port and sequencer
  // ----------------------------------------
  always_comb begin
    heat_conv_cmd_bits_d = heat_conv_cmd_bits_q;
    irq_en_d = irq_en_q;
    heat_ready_flag_d = heat_ready_flag_q;
    raw_temp_d = raw_temp_q;
    first_res_d = first_res_q;
    gain_d = gain_q;
    pulse_source_config_d = pulse_source_config_q;
    thr_d = thr_q;
    sample_rate_setting_d = sample_rate_setting_q;
    state_d = state_q;
    start_d = 1'b0;
    bias_d = bias_q;
    rdata_d = 32'h0000_0000;

    if (wr_i) begin
      unique case (addr_i)
        `DTC_OFS_OPCFG: begin
          irq_en_d = wdata_i[`DTC_BIT_IRQ_EN];
          // Busy sequencer keeps its command untouched
          if (!busy) begin // R20
            heat_conv_cmd_bits_d = {wdata_i[`DTC_BIT_DOUBLE], wdata_i[`DTC_BIT_SINGLE]}; // R1
          end
        end
        `DTC_OFS_FLAGS: begin
          if (wdata_i[`DTC_BIT_READY]) begin
            heat_ready_flag_d = 1'b0; // R9
          end
        end
        `DTC_OFS_I_GAIN: gain_d[0] = wdata_i[15:0]; // R18
        `DTC_OFS_V_GAIN: gain_d[1] = wdata_i[15:0]; // R18
        `DTC_OFS_E_GAIN: gain_d[2] = wdata_i[15:0]; // R18
        `DTC_OFS_PULSE_CFG: pulse_source_config_d = wdata_i[15:0]; // R13
        `DTC_OFS_PULSE1_THRESHOLD: thr_d[0] = wdata_i; // R16
        `DTC_OFS_PULSE2_THRESHOLD: thr_d[1] = wdata_i; // R16
        `DTC_OFS_RATE: sample_rate_setting_d = wdata_i[15:0]; // R17
        default: begin
        end
      endcase
    end

    if (rd_i) begin
      unique case (addr_i)
        `DTC_OFS_OPCFG: begin
          rdata_d[`DTC_BIT_SINGLE] = heat_conv_cmd_bits_q[0];
          rdata_d[`DTC_BIT_DOUBLE] = heat_conv_cmd_bits_q[1];
          rdata_d[`DTC_BIT_IRQ_EN] = irq_en_q;
        end
        `DTC_OFS_FLAGS: rdata_d[`DTC_BIT_READY] = heat_ready_flag_q;
        `DTC_OFS_RAW_TEMP: rdata_d = {16'h0000, raw_temp_q}; // R5
        `DTC_OFS_I_GAIN: rdata_d = {16'h0000, gain_q[0]};
        `DTC_OFS_V_GAIN: rdata_d = {16'h0000, gain_q[1]};
        `DTC_OFS_E_GAIN: rdata_d = {16'h0000, gain_q[2]};
        `DTC_OFS_PULSE_CFG: rdata_d = {16'h0000, pulse_source_config_q};
        `DTC_OFS_PULSE1_THRESHOLD: rdata_d = thr_q[0];
        `DTC_OFS_PULSE2_THRESHOLD: rdata_d = thr_q[1];
        `DTC_OFS_RATE: rdata_d = {16'h0000, sample_rate_setting_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end

    unique case (state_q)
      DTC_IDLE: begin
        // Only a host command leaves idle
        if (heat_conv_cmd_bits_q != 2'b00) begin // R1
          state_d = DTC_CONV1;
          start_d = 1'b1;
          bias_d = 1'b0; // R2
        end
      end
      DTC_CONV1: begin
        if (conv_done_i) begin
          if (heat_conv_cmd_bits_q[1]) begin
            first_res_d = conv_data_i;
            state_d = DTC_CONV2;
            start_d = 1'b1;
            bias_d = 1'b1; // R3
          end else begin
            raw_temp_d = conv_data_i; // R2
            state_d = DTC_STORE;
          end
        end
      end
      DTC_CONV2: begin
        if (conv_done_i) begin
          // Averaging cancels the diode offset of one bias order
          raw_temp_d = temp_sum[16:1]; // R4
          state_d = DTC_STORE;
        end
      end
      DTC_STORE: begin
        // Result already stored a cycle earlier
        heat_conv_cmd_bits_d = 2'b00; // R4
        bias_d = 1'b0;
        state_d = DTC_IDLE;
      end
    endcase

    // Hardware set wins over a same-cycle host clear
    if (state_q == DTC_STORE) begin
      heat_ready_flag_d = 1'b1; // R7
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      heat_conv_cmd_bits_q <= 2'b00;
      irq_en_q <= 1'b0;
      heat_ready_flag_q <= 1'b0;
      raw_temp_q <= 16'h0000;
      first_res_q <= 16'h0000;
      for (int k = 0; k < 3; k++) begin
        gain_q[k] <= `DTC_GAIN_RST; // R10
      end
      pulse_source_config_q <= 16'h0000;
      thr_q[0] <= 32'h0000_0000;
      thr_q[1] <= 32'h0000_0000;
      sample_rate_setting_q <= `DTC_RATE_RST; // R17
      rdata_q <= 32'h0000_0000;
      state_q <= DTC_IDLE;
      start_q <= 1'b0;
      bias_q <= 1'b0;
    end else begin
      heat_conv_cmd_bits_q <= heat_conv_cmd_bits_d;
      irq_en_q <= irq_en_d;
      heat_ready_flag_q <= heat_ready_flag_d;
      raw_temp_q <= raw_temp_d;
      first_res_q <= first_res_d;
      gain_q <= gain_d;
      pulse_source_config_q <= pulse_source_config_d;
      thr_q <= thr_d;
      sample_rate_setting_q <= sample_rate_setting_d;
      rdata_q <= rdata_d;
      state_q <= state_d;
      start_q <= start_d;
      bias_q <= bias_d;
    end
  end

  assign rdata_o = rdata_q;
  assign conv_start_o = start_q;
  assign bias_rev_o = bias_q;
  assign irq_o = heat_ready_flag_q & irq_en_q; // R8

  // ----------------------------------------
  // Gain correction
  // ----------------------------------------
  logic [31:0] raw_in [3];
  logic [31:0] corr_w [3];
  logic [31:0] corr_q [3];

  // Full-scale input arrives as 2^30 RMS and 2^18/(fline*period) energy
  assign raw_in[0] = irms_raw_i; // R11
  assign raw_in[1] = vrms_raw_i; // R11
  assign raw_in[2] = energy_raw_i; // R12

  for (genvar g = 0; g < 3; g++) begin : g_corr
    dtc_gain_corr u_corr (
      .raw_i(raw_in[g]),
      .coef_i(gain_q[g]),
      .corr_o(corr_w[g])
    ); // R19
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int k = 0; k < 3; k++) begin
        corr_q[k] <= 32'h0000_0000;
      end
    end else begin
      corr_q <= corr_w;
    end
  end

  assign irms_corr_o = corr_q[0];
  assign vrms_corr_o = corr_q[1];
  assign energy_corr_o = corr_q[2];

  // ----------------------------------------
  // Sample period
  // ----------------------------------------
  logic [2:0] clk_cnt_q, clk_cnt_d;
  logic [15:0] unit_cnt_q, unit_cnt_d;
  logic tick_q, tick_d;

  always_comb begin
    clk_cnt_d = clk_cnt_q + 3'h1;
    unit_cnt_d = unit_cnt_q;
    tick_d = 1'b0;
    if (clk_cnt_q == `DTC_CLKS_PER_UNIT_M1) begin
      // Rate rewrite takes effect at the next period boundary or earlier
      if (unit_cnt_q >= sample_rate_setting_q) begin // R17
        unit_cnt_d = 16'h0000;
        tick_d = 1'b1;
      end else begin
        unit_cnt_d = unit_cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      clk_cnt_q <= 3'h0;
      unit_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      clk_cnt_q <= clk_cnt_d;
      unit_cnt_q <= unit_cnt_d;
      tick_q <= tick_d;
    end
  end

  assign sample_tick_o = tick_q;

  // ----------------------------------------
  // Pulse outputs
  // ----------------------------------------
  // Returns {valid, phase index} for one byte of the pulse source config
  function automatic logic [2:0] dtc_phase_sel(input logic [7:0] code);
    logic [2:0] res;
    res = 3'b000;
    if (code[7:4] == `DTC_APPARENT_CODE) begin
      unique case (code[3:0])
        `DTC_PHASE_A: res = 3'b100;
        `DTC_PHASE_B: res = 3'b101;
        `DTC_PHASE_C: res = 3'b110;
        default: res = 3'b000;
      endcase
    end
    return res;
  endfunction : dtc_phase_sel

  logic [31:0] va_in [3];
  logic [32:0] acc_q [2];
  logic [32:0] acc_d [2];
  logic pulse_q [2];
  logic pulse_d [2];
  logic [2:0] sel [2];

  assign va_in[0] = va_energy_a_i;
  assign va_in[1] = va_energy_b_i;
  assign va_in[2] = va_energy_c_i;
  assign sel[0] = dtc_phase_sel(pulse_source_config_q[7:0]); // R13
  assign sel[1] = dtc_phase_sel(pulse_source_config_q[15:8]); // R13

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      acc_d[c] = acc_q[c];
      pulse_d[c] = pulse_q[c];
      if (tick_q) begin
        // Pulse lasts one sample period
        pulse_d[c] = 1'b0;
        if (sel[c][2]) begin
          acc_d[c] = acc_q[c] + {1'b0, va_in[sel[c][1:0]]};
          // Zero threshold holds the pin low instead of pulsing every tick
          if (thr_q[c] != 32'h0000_0000 && acc_d[c] >= {1'b0, thr_q[c]}) begin // R15
            acc_d[c] = acc_d[c] - {1'b0, thr_q[c]};
            pulse_d[c] = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int c = 0; c < 2; c++) begin
        acc_q[c] <= 33'h0_0000_0000;
        pulse_q[c] <= 1'b0;
      end
    end else begin
      acc_q <= acc_d;
      pulse_q <= pulse_d;
    end
  end

  assign active_pulse_pin_o = pulse_q[0]; // R14
  assign second_pulse_pin_o = pulse_q[1]; // R14

endmodule : dtc_ctrl

//--- dtc_params.svh
// Constants of the die temperature and metering calibration control slice.
// Assumes inclusion by bare name from the package only; the design modules use its macros from there.
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define DTC_ADDR_W 8
`define DTC_OFS_OPCFG 8'h00
`define DTC_OFS_FLAGS 8'h04
`define DTC_OFS_RAW_TEMP 8'h08
`define DTC_OFS_I_GAIN 8'h0C
`define DTC_OFS_V_GAIN 8'h10
`define DTC_OFS_E_GAIN 8'h14
`define DTC_OFS_PULSE_CFG 8'h18
`define DTC_OFS_PULSE1_THRESHOLD 8'h1C
`define DTC_OFS_PULSE2_THRESHOLD 8'h20
`define DTC_OFS_RATE 8'h24

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DTC_BIT_SINGLE 0
`define DTC_BIT_DOUBLE 1
`define DTC_BIT_IRQ_EN 2
`define DTC_BIT_READY 0

// ----------------------------------------
// Reset values and figures
// ----------------------------------------
`define DTC_RATE_RST 16'h00C7
`define DTC_CLKS_PER_UNIT_M1 3'h7
`define DTC_GAIN_RST 16'h0000
`define DTC_SHIFT_GAIN 16
`define DTC_FS_RMS_RAW 32'h4000_0000
`define DTC_FS_EPC_RAW 32'h0004_0000
`define DTC_APPARENT_CODE 4'h2
`define DTC_PHASE_A 4'h1
`define DTC_PHASE_B 4'h2
`define DTC_PHASE_C 4'h4

`endif

//--- dtc_pkg.sv
// Types shared by the temperature sequencer and the calibration datapath.
// Assumes dtc_params.svh is on the include path.
`include "dtc_params.svh"

package dtc_pkg;

  typedef enum logic [1:0] {
    DTC_IDLE  = 2'b00,
    DTC_CONV1 = 2'b01,
    DTC_CONV2 = 2'b10,
    DTC_STORE = 2'b11
  } dtc_state_t;

  typedef logic signed [15:0] dtc_coef_t;

endpackage : dtc_pkg

//--- dtc_gain_corr.sv
// Gain correction of one raw RMS or energy result.
// Assumes an unsigned raw value and a signed coefficient in 1/65536 steps.
`timescale 1ns/1ps

module dtc_gain_corr
  import dtc_pkg::*;
(
  input wire logic [31:0] raw_i,
  input wire dtc_coef_t coef_i,
  output logic [31:0] corr_o
);

  logic signed [48:0] prod;
  logic signed [33:0] sum;

  // Result = raw * (1 + coef / 65536), clipped to the unsigned range
  always_comb begin
    prod = $signed({1'b0, raw_i}) * coef_i;
    sum = $signed({2'b00, raw_i}) + $signed({prod[48], prod[48:`DTC_SHIFT_GAIN]});
    if (sum[33]) begin
      corr_o = 32'h0000_0000;
    end else if (sum[32]) begin
      corr_o = 32'hFFFF_FFFF;
    end else begin
      corr_o = sum[31:0];
    end
  end

endmodule : dtc_gain_corr

//--- dtc_conv_model.sv
// Converter model on the far side of the temperature start/done link.
// Assumes one start at a time and a latency of at least one cycle.
`timescale 1ns/1ps

module dtc_conv_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic conv_start_i,
  input wire logic bias_rev_i,
  input wire logic [7:0] lat_i,
  input wire logic [15:0] norm_i,
  input wire logic [15:0] rev_i,
  output logic conv_done_o,
  output logic [15:0] conv_data_o
);
  logic [7:0] cnt_q;
  logic rev_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= 8'h00;
      rev_q <= 1'b0;
      conv_done_o <= 1'b0;
      conv_data_o <= 16'h0000;
    end else begin
      conv_done_o <= 1'b0;
      // Toggles outside done so stale data never matches
      conv_data_o <= ~conv_data_o;
      if (conv_start_i) begin
        cnt_q <= lat_i;
        rev_q <= bias_rev_i;
      end else if (cnt_q == 8'h01) begin
        cnt_q <= 8'h00;
        conv_done_o <= 1'b1;
        conv_data_o <= rev_q ? rev_i : norm_i;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule : dtc_conv_model

//--- dtc_ctrl_asserts.sv
// Port checks for the temperature sequencer, bus and pulse outputs.
// Assumes it is bound into dtc_ctrl.
`timescale 1ns/1ps

module dtc_ctrl_asserts (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic irq_o,
  input wire logic conv_start_o,
  input wire logic bias_rev_o,
  input wire logic conv_done_i,
  input wire logic sample_tick_o,
  input wire logic active_pulse_pin_o,
  input wire logic second_pulse_pin_o
);
  logic [15:0] rate_q;
  logic [19:0] gap_q;
  logic armed_q;

  // A rate rewrite may cut a period short, so one period is skipped
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rate_q <= 16'h00C7;
      gap_q <= 20'h0;
      armed_q <= 1'b0;
    end else begin
      gap_q <= sample_tick_o ? 20'h1 : gap_q + 20'h1;
      if (wr_i && addr_i == 8'h24) begin
        rate_q <= wdata_i[15:0];
        armed_q <= 1'b0;
      end else if (sample_tick_o) begin
        armed_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  start_cmd_a: assert property (conv_start_o && !bias_rev_o |->
    $past(wr_i && addr_i == 8'h00 && wdata_i[1:0] != 2'b00, 2))
    else $error("start without command");
  start_rev_a: assert property (conv_start_o && bias_rev_o |-> $past(conv_done_i))
    else $error("reversed start not after first done");
  bias_end_a: assert property ($fell(bias_rev_o) |->
    $past(conv_done_i) || $past(conv_done_i, 2))
    else $error("bias dropped early");
  irq_rise_a: assert property ($rose(irq_o) |-> $past(conv_done_i, 2) || $past(wr_i))
    else $error("irq rose without cause");
  rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside read slot");
  unmapped_a: assert property (rd_i && addr_i > 8'h24 |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  tick_gap_a: assert property (sample_tick_o && armed_q |->
    gap_q == (({4'h0, rate_q} + 20'h1) << 3))
    else $error("sample period wrong");
  pulse1_a: assert property ($rose(active_pulse_pin_o) |-> $past(sample_tick_o))
    else $error("pulse 1 off tick");
  pulse2_a: assert property ($rose(second_pulse_pin_o) |-> $past(sample_tick_o))
    else $error("pulse 2 off tick");
endmodule : dtc_ctrl_asserts

bind dtc_ctrl dtc_ctrl_asserts u_dtc_ctrl_asserts (.clk_i, .reset_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .irq_o, .conv_start_o, .bias_rev_o, .conv_done_i,
  .sample_tick_o, .active_pulse_pin_o, .second_pulse_pin_o);

//--- die_temp_and_meter_cal_ctrl_tb.sv
// Self-checking bench for the temperature and calibration control slice.
// Assumes package, converter model and checker are compiled before it.
`timescale 1ns/1ps

module die_temp_and_meter_cal_ctrl_tb;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o, irms_corr_o, vrms_corr_o, energy_corr_o;
  logic irq_o, conv_start_o, bias_rev_o, conv_done_i;
  logic sample_tick_o, active_pulse_pin_o, second_pulse_pin_o;
  logic [15:0] conv_data_i;
  logic [31:0] irms_raw_i = 32'h0, vrms_raw_i = 32'h0, energy_raw_i = 32'h0;
  logic [31:0] va_a = 32'h0, va_b = 32'h0, va_c = 32'h0;
  logic [7:0] lat = 8'h04;
  logic [7:0] bias_log = 8'h00;
  logic [15:0] norm_val = 16'h0000, rev_val = 16'h0000;
  int bad_count = 0, cmp_count = 0, cyc = 0, starts = 0;

  always #12.5 clk_i = ~clk_i;

  dtc_ctrl u_dtc_ctrl (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o,
    .conv_start_o, .bias_rev_o, .conv_done_i, .conv_data_i, .irms_raw_i, .vrms_raw_i,
    .energy_raw_i, .irms_corr_o, .vrms_corr_o, .energy_corr_o, .va_energy_a_i(va_a),
    .va_energy_b_i(va_b), .va_energy_c_i(va_c), .sample_tick_o, .active_pulse_pin_o,
    .second_pulse_pin_o);

  dtc_conv_model u_dtc_conv_model (.clk_i, .reset_i, .conv_start_i(conv_start_o),
    .bias_rev_i(bias_rev_o), .lat_i(lat), .norm_i(norm_val), .rev_i(rev_val),
    .conv_done_o(conv_done_i), .conv_data_o(conv_data_i));

  task automatic wrap_up();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // Ceiling well above the roughly 1300 cycles the run needs
  always @(posedge clk_i) begin
    cyc++;
    if (conv_start_o === 1'b1) begin
      starts++;
      bias_log <= {bias_log[6:0], bias_rev_o};
    end
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask : bus_rd

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk({31'h0, irq_o}, 32'h1);
  endtask : wait_irq

  task automatic t_regs();
    repeat (20) @(posedge clk_i);
    chk(starts, 0);
    for (int i = 0; i <= 12; i++) begin
      bus_rd(8'(i * 4), (i == 9) ? 32'hC7 : 32'h0);
    end
    bus_wr(8'h1C, 32'hFFFF_FFFF);
    bus_rd(8'h1C, 32'hFFFF_FFFF);
    bus_wr(8'h30, 32'hFFFF_FFFF);
    bus_rd(8'h30, 32'h0);
  endtask : t_regs

  task automatic t_single();
    norm_val <= 16'hA5C3;
    bus_wr(8'h00, 32'h5);
    wait_irq();
    chk({24'h0, bias_log}, 32'h0);
    chk(starts, 1);
    bus_rd(8'h08, 32'h0000_A5C3);
    bus_rd(8'h00, 32'h4);
    bus_rd(8'h04, 32'h1);
    bus_wr(8'h04, 32'h1);
    @(posedge clk_i);
    #1;
    chk({31'h0, irq_o}, 32'h0);
  endtask : t_single

  task automatic t_double();
    lat <= 8'd30;
    norm_val <= 16'hF000;
    rev_val <= 16'hE002;
    bus_wr(8'h00, 32'h6);
    bus_wr(8'h00, 32'h5);
    wait_irq();
    chk(starts, 3);
    chk({30'h0, bias_log[1:0]}, 32'h1);
    bus_rd(8'h08, 32'h0000_E801);
    bus_rd(8'h00, 32'h4);
    bus_wr(8'h04, 32'h1);
  endtask : t_double

  task automatic t_gain();
    irms_raw_i <= 32'h4000_0000;
    vrms_raw_i <= 32'h4000_0000;
    energy_raw_i <= 32'h0004_0000;
    bus_wr(8'h0C, 32'h8000);
    bus_wr(8'h14, 32'h4000);
    bus_rd(8'h0C, 32'h0000_8000);
    chk(irms_corr_o, 32'h2000_0000);
    chk(vrms_corr_o, 32'h4000_0000);
    chk(energy_corr_o, 32'h0005_0000);
    bus_wr(8'h0C, 32'h0);
    repeat (2) @(posedge clk_i);
    #1;
    chk(irms_corr_o, 32'h4000_0000);
  endtask : t_gain

  task automatic t_pulse();
    logic [15:0] codes [6];
    logic [3:0] ph;
    logic sel;
    logic prev;
    logic cur;
    int gap;
    int rises;
    codes = '{16'h0021, 16'h0022, 16'h0024, 16'h2100, 16'h2200, 16'h2400};
    bus_wr(8'h24, 32'h3);
    bus_wr(8'h1C, 32'h10);
    bus_wr(8'h20, 32'h20);
    for (int i = 0; i < 6; i++) begin
      sel = (i >= 3);
      ph = sel ? codes[i][11:8] : codes[i][3:0];
      va_a <= ph[0] ? 32'h8 : 32'h0;
      va_b <= ph[1] ? 32'h8 : 32'h0;
      va_c <= ph[2] ? 32'h8 : 32'h0;
      bus_wr(8'h18, {16'h0, codes[i]});
      rises = 0;
      gap = 0;
      prev = 1'b1;
      for (int n = 0; n < 600 && rises < 2; n++) begin
        @(posedge clk_i);
        #1;
        cur = sel ? second_pulse_pin_o : active_pulse_pin_o;
        if (rises == 1) gap++;
        if (cur === 1'b1 && prev !== 1'b1) rises++;
        prev = cur;
      end
      chk(gap, sel ? (3 + 1) * 8 * 4 : (3 + 1) * 8 * 2);
      chk({31'h0, sel ? active_pulse_pin_o : second_pulse_pin_o}, 32'h0);
    end
  endtask : t_pulse

  initial begin
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs();
    t_single();
    t_double();
    t_gain();
    t_pulse();
    wrap_up();
  end
endmodule : die_temp_and_meter_cal_ctrl_tb
